// File: hdl/dphy_timing_override_regs.v
// APB register bank for D-PHY trail, exit and LP transition timing
//
// Notes on behaviour
// [R01] Trail register: override bit seven, value below
// [R02] Exit register: override bit, value default 0x0B
// [R03] LP transition register: override bit, default 0x6
// [R04] Override clear: value ignores writes, reads auto
// [R05] Override set: value writable; bit and value set in one write
// [R06] Auto values follow lane rate, 800 default
// [R07] Transmitter uses override only while bit set
`timescale 1ns/100ps
`default_nettype none
`include "dphy_timing_defines.vh"
module dphy_timing_override_regs #(
  parameter VAL_W = `VAL_W
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clk_en,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  input  wire [3:0]       pstrb,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  output reg  [VAL_W-1:0] trail_time_eff,
  output reg  [VAL_W-1:0] exit_time_eff,
  output reg  [VAL_W-1:0] lp_transition_eff
);

  // Select codes from the address decode
  localparam SEL_NONE  = 3'd0;
  localparam SEL_TRAIL = 3'd1;
  localparam SEL_EXIT  = 3'd2;
  localparam SEL_LPX   = 3'd3;
  localparam SEL_RATE  = 3'd4;

  // Trail register state
  reg              trail_time_override_reg;
  reg [VAL_W-1:0]  trail_time_value_reg;

  // Exit register state
  reg              exit_time_override_reg;
  reg [VAL_W-1:0]  exit_time_value_reg;

  // LP transition register state
  reg              lp_transition_override_reg;
  reg [VAL_W-1:0]  lp_transition_value_reg;

  // Lane-rate select state
  reg [2:0]        lane_rate_reg;

  // Effective next values
  reg [VAL_W-1:0]  trail_time_eff_next;
  reg [VAL_W-1:0]  exit_time_eff_next;
  reg [VAL_W-1:0]  lp_transition_eff_next;

  // Read path
  reg [31:0]       rdata_next;
  wire [7:0]       trail_rd_byte;
  wire [7:0]       exit_rd_byte;
  wire [7:0]       lpx_rd_byte;
  wire [7:0]       rate_rd_byte;

  // Table outputs
  wire [VAL_W-1:0] auto_trail;
  wire [VAL_W-1:0] auto_exit;
  wire [VAL_W-1:0] auto_lpx;

  // Bus decode and write strobes
  wire [2:0]       sel;
  wire             wr_en;
  wire             rd_en;
  wire             setup_phase;
  wire             access_phase;
  wire             hit;
  wire             wr_trail;
  wire             wr_exit;
  wire             wr_lpx;
  wire             wr_rate;
  wire             ld_trail;
  wire             ld_exit;
  wire             ld_lpx;
  wire             wr_ovr;
  wire [VAL_W-1:0] wr_val;
  wire [2:0]       wr_rate_code;

  // Address decode shared by read and write paths
  function [2:0] decode;
    input [11:0] a;
    begin
      if (a == `TRAIL_ADDR) begin
        decode = SEL_TRAIL;
      end else if (a == `EXIT_ADDR) begin
        decode = SEL_EXIT;
      end else if (a == `LPX_ADDR) begin
        decode = SEL_LPX;
      end else if (a == `RATE_ADDR) begin
        decode = SEL_RATE;
      end else begin
        decode = SEL_NONE;
      end
    end
  endfunction

  // Pick value shown and used: auto or software
  function [VAL_W-1:0] pick;
    input             ovr;
    input [VAL_W-1:0] sw_val;
    input [VAL_W-1:0] auto_val;
    begin
      pick = ovr ? sw_val : auto_val;
    end
  endfunction

  // Bus phases as seen by this slave
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit          = (sel != SEL_NONE);

  // Zero-wait slave; unmapped addresses answer with an error
  assign sel     = decode(paddr);
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~hit;
  assign wr_en   = clk_en & access_phase & pwrite & pstrb[0] & hit;
  assign rd_en   = clk_en & setup_phase & ~pwrite;

  // Write data fields
  assign wr_ovr       = pwdata[`OVR_BIT];
  assign wr_val       = pwdata[`VAL_MSB:0];
  assign wr_rate_code = pwdata[2:0];

  // Per-register write strobes
  assign wr_trail = wr_en & (sel == SEL_TRAIL);
  assign wr_exit  = wr_en & (sel == SEL_EXIT);
  assign wr_lpx   = wr_en & (sel == SEL_LPX);
  assign wr_rate  = wr_en & (sel == SEL_RATE);

  // [R04] Writes ignored without override
  // [R05] Override and value in one write
  assign ld_trail = wr_trail & wr_ovr;
  assign ld_exit  = wr_exit & wr_ovr;
  assign ld_lpx   = wr_lpx & wr_ovr;

  // [R06] Rate-driven auto values
  rate_timing_table #(
    .W (VAL_W)
  ) u_table (
    .pclk       (pclk),
    .presetn    (presetn),
    .clk_en     (clk_en),
    .lane_rate  (lane_rate_reg),
    .auto_trail (auto_trail),
    .auto_exit  (auto_exit),
    .auto_lpx   (auto_lpx)
  );

  // [R01] Trail override bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trail_time_override_reg <= `OVR_RST;
    end else if (wr_trail) begin
      trail_time_override_reg <= wr_ovr;
    end
  end

  // [R02] Exit override bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_time_override_reg <= `OVR_RST;
    end else if (wr_exit) begin
      exit_time_override_reg <= wr_ovr;
    end
  end

  // [R03] LP transition override bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_transition_override_reg <= `OVR_RST;
    end else if (wr_lpx) begin
      lp_transition_override_reg <= wr_ovr;
    end
  end

  // [R06] Lane-rate select register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_rate_reg <= `RATE_RST;
    end else if (wr_rate) begin
      lane_rate_reg <= wr_rate_code;
    end
  end

  // Trail value, loaded only with override set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trail_time_value_reg <= `TRAIL_RST;
    end else if (ld_trail) begin
      trail_time_value_reg <= wr_val;
    end
  end

  // Exit value, loaded only with override set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_time_value_reg <= `EXIT_RST;
    end else if (ld_exit) begin
      exit_time_value_reg <= wr_val;
    end
  end

  // LP transition value, loaded only with override set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_transition_value_reg <= `LPX_RST;
    end else if (ld_lpx) begin
      lp_transition_value_reg <= wr_val;
    end
  end

  // [R07] Trail effective selection
  always @* begin
    trail_time_eff_next = pick(trail_time_override_reg, trail_time_value_reg, auto_trail);
  end

  // [R07] Exit effective selection
  always @* begin
    exit_time_eff_next = pick(exit_time_override_reg, exit_time_value_reg, auto_exit);
  end

  // [R07] LP transition effective selection
  always @* begin
    lp_transition_eff_next = pick(lp_transition_override_reg, lp_transition_value_reg, auto_lpx);
  end

  // Trail timing output register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trail_time_eff <= `TRAIL_RST;
    end else if (clk_en) begin
      trail_time_eff <= trail_time_eff_next;
    end
  end

  // Exit timing output register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_time_eff <= `EXIT_RST;
    end else if (clk_en) begin
      exit_time_eff <= exit_time_eff_next;
    end
  end

  // LP transition timing output register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_transition_eff <= `LPX_RST;
    end else if (clk_en) begin
      lp_transition_eff <= lp_transition_eff_next;
    end
  end

  // [R04] Read bytes: override bit over shown value, zeros over the rate code
  assign trail_rd_byte = {trail_time_override_reg, trail_time_eff_next};
  assign exit_rd_byte  = {exit_time_override_reg, exit_time_eff_next};
  assign lpx_rd_byte   = {lp_transition_override_reg, lp_transition_eff_next};
  assign rate_rd_byte  = {5'h00, lane_rate_reg};

  // Read word for a decoded select; bits above byte 0 read zero
  function [31:0] read_word;
    input [2:0] s;
    input [7:0] tr_b;
    input [7:0] ex_b;
    input [7:0] lp_b;
    input [7:0] rt_b;
    begin
      read_word = 32'h0000_0000;
      if (s == SEL_TRAIL) begin
        read_word[7:0] = tr_b;
      end else if (s == SEL_EXIT) begin
        read_word[7:0] = ex_b;
      end else if (s == SEL_LPX) begin
        read_word[7:0] = lp_b;
      end else if (s == SEL_RATE) begin
        read_word[7:0] = rt_b;
      end
    end
  endfunction

  // [R04] Read mux shows auto value without override
  always @* begin
    rdata_next = read_word(sel, trail_rd_byte, exit_rd_byte, lpx_rd_byte, rate_rd_byte);
  end

  // Read data captured in the setup cycle, held through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rdata_next;
    end
  end

endmodule
`default_nettype wire

// File: hdl/dphy_timing_defines.vh
// Register offsets, field layout, reset values and lane-rate codes
`ifndef DPHY_TIMING_DEFINES_VH
`define DPHY_TIMING_DEFINES_VH

// Printed offsets are register indices; byte address is index times four
`define TRAIL_IDX        8'h46
`define EXIT_IDX         8'h47
`define LPX_IDX          8'h68
`define TRAIL_ADDR       12'h118
`define EXIT_ADDR        12'h11C
`define LPX_ADDR         12'h1A0
`define RATE_ADDR        12'h200

// Field layout
`define OVR_BIT          7
`define VAL_MSB          6
`define VAL_W            7

// Reset values
`define OVR_RST          1'b0
`define TRAIL_RST        7'h08
`define EXIT_RST         7'h0B
`define LPX_RST          7'h06
`define RATE_RST         3'h1

// Lane-rate codes
`define RATE_400         3'h0
`define RATE_800         3'h1
`define RATE_1200        3'h2
`define RATE_1500        3'h3
`define RATE_1600        3'h4

`endif

// File: hdl/rate_timing_table.v
// Lane-rate to automatic timing value lookup with registered outputs
`timescale 1ns/100ps
`default_nettype none
`include "dphy_timing_defines.vh"
module rate_timing_table #(
  parameter W = 7
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         clk_en,
  input  wire [2:0]   lane_rate,
  output reg  [W-1:0] auto_trail,
  output reg  [W-1:0] auto_exit,
  output reg  [W-1:0] auto_lpx
);

  reg [W-1:0] trail_next;
  reg [W-1:0] exit_next;
  reg [W-1:0] lpx_next;

  // Table of derived values per lane rate
  always @* begin
    trail_next = `TRAIL_RST;
    exit_next  = `EXIT_RST;
    lpx_next   = `LPX_RST;
    case (lane_rate)
      `RATE_400: begin
        trail_next = 7'h05;
        exit_next  = 7'h06;
        lpx_next   = 7'h03;
      end
      `RATE_1200: begin
        trail_next = 7'h0B;
        exit_next  = 7'h10;
        lpx_next   = 7'h09;
      end
      `RATE_1500: begin
        trail_next = 7'h0D;
        exit_next  = 7'h14;
        lpx_next   = 7'h0B;
      end
      `RATE_1600: begin
        trail_next = 7'h0E;
        exit_next  = 7'h15;
        lpx_next   = 7'h0C;
      end
      default: begin
        trail_next = `TRAIL_RST;
        exit_next  = `EXIT_RST;
        lpx_next   = `LPX_RST;
      end
    endcase
  end

  // Registered table outputs, 800 Mbps values at reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_trail <= `TRAIL_RST;
      auto_exit  <= `EXIT_RST;
      auto_lpx   <= `LPX_RST;
    end else if (clk_en) begin
      auto_trail <= trail_next;
      auto_exit  <= exit_next;
      auto_lpx   <= lpx_next;
    end
  end

endmodule
`default_nettype wire

// File: verif/dphy_timing_props.sv
// Assertion checker for the timing override register bank
`timescale 1ns/100ps
`default_nettype none
`include "dphy_timing_defines.vh"
module dphy_timing_props #(
  parameter VAL_W = 7
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             clk_en,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [3:0]       pstrb,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [VAL_W-1:0] trail_time_eff,
  input wire logic [VAL_W-1:0] exit_time_eff,
  input wire logic [VAL_W-1:0] lp_transition_eff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access decode
  wire acc = psel && penable;
  wire hit = paddr == `TRAIL_ADDR || paddr == `EXIT_ADDR || paddr == `LPX_ADDR;
  wire map = hit || paddr == `RATE_ADDR;
  wire wt  = acc && pwrite && clk_en && pstrb[0] && paddr == `TRAIL_ADDR;
  property p_rst_tr; $rose(presetn) |-> trail_time_eff == `TRAIL_RST; endproperty
  property p_rst_ex; $rose(presetn) |-> exit_time_eff == `EXIT_RST; endproperty
  property p_rst_lp; $rose(presetn) |-> lp_transition_eff == `LPX_RST; endproperty
  property p_ovr; wt && pwdata[7] ##1 clk_en |=> trail_time_eff == $past(pwdata[6:0], 2);
  endproperty
  property p_err; acc && !map |-> pslverr; endproperty
  property p_noerr; !acc || map |-> !pslverr; endproperty
  property p_rdy; pready; endproperty
  property p_hi; prdata[31:8] == 24'h00_0000; endproperty
  property p_frz; !clk_en |=> $stable(trail_time_eff) && $stable(exit_time_eff)
    && $stable(lp_transition_eff); endproperty
  a_rst_tr: assert property (p_rst_tr) else $error("trail reset value wrong");
  a_rst_ex: assert property (p_rst_ex) else $error("exit reset value wrong");
  a_rst_lp: assert property (p_rst_lp) else $error("lp reset value wrong");
  a_ovr: assert property (p_ovr) else $error("override value not applied");
  a_err: assert property (p_err) else $error("no error on unmapped");
  a_noerr: assert property (p_noerr) else $error("spurious error");
  a_rdy: assert property (p_rdy) else $error("ready low");
  a_hi: assert property (p_hi) else $error("upper read bits set");
  a_frz: assert property (p_frz) else $error("output moved while frozen");
  c_ovr: cover property (wt && pwdata[7]);
  c_err: cover property (acc && !map);
  c_frz: cover property (!clk_en);
endmodule
bind dphy_timing_override_regs dphy_timing_props #(.VAL_W(VAL_W)) u_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trail_time_eff(trail_time_eff),
  .exit_time_eff(exit_time_eff), .lp_transition_eff(lp_transition_eff));
`default_nettype wire

// File: verif/dphy_timing_override_regs_tb_top.sv
// Self-checking bench for the timing override register bank
`timescale 1ns/100ps
`default_nettype none
`include "dphy_timing_defines.vh"
module dphy_timing_override_regs_tb_top;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [3:0]  pstrb;
  logic [6:0]  trail_time_eff, exit_time_eff, lp_transition_eff;
  logic [11:0] adr [3] = '{`TRAIL_ADDR, `EXIT_ADDR, `LPX_ADDR};
  integer      fails = 0, check_count = 0, cyc = 0, seed = 32'h30e5, rate = 1, k;
  integer      ovr [3], sw [3], codes [6] = '{0, 1, 2, 3, 4, 7};

  dphy_timing_override_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trail_time_eff(trail_time_eff), .exit_time_eff(exit_time_eff),
    .lp_transition_eff(lp_transition_eff));

  // Automatic value per lane rate
  function automatic [6:0] aut(input integer j);
    logic [23:0] t;
    case (rate)
      0: t = 24'h05_0603;
      2: t = 24'h0b_1009;
      3: t = 24'h0d_140b;
      4: t = 24'h0e_150c;
      default: t = 24'h08_0b06;
    endcase
    aut = t[8*(2-j) +: 7];
  endfunction
  function automatic [31:0] expv(input integer j);
    expv = {24'h00_0000, ovr[j][0], ovr[j] ? sw[j][6:0] : aut(j)};
  endfunction
  task chk(input [31:0] g, input [31:0] x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("Error %0t got %h exp %h", $time, g, x);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer, waits for ready
  task apb(input [11:0] a, input w, input [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(a, 1, d);
    for (int j = 0; j < 3; j++) if (a == adr[j] && pstrb[0] && clk_en) begin
      ovr[j] = d[7];
      if (d[7]) sw[j] = d[6:0];
    end
    if (a == `RATE_ADDR && pstrb[0] && clk_en) rate = d[2:0];
  endtask
  task rdc(input integer j);
    apb(adr[j], 0, 0);
    chk(r, expv(j));
  endtask
  task effc;
    repeat (3) @(posedge pclk);
    #1 chk({25'h0, trail_time_eff}, expv(0) & 32'h7f);
    chk({25'h0, exit_time_eff}, expv(1) & 32'h7f);
    chk({25'h0, lp_transition_eff}, expv(2) & 32'h7f);
    @(posedge pclk);
  endtask
  // Clock
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      fails++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 4'hf; ovr = '{0, 0, 0}; sw = '{0, 0, 0};
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (k = 0; k < 3; k++) rdc(k);
    for (k = 0; k < 3; k++) begin
      wr(adr[k], $random(seed) & 32'h7f);
      rdc(k);
    end
    foreach (codes[c]) begin
      wr(`RATE_ADDR, codes[c]);
      for (k = 0; k < 3; k++) rdc(k);
      effc;
    end
    for (k = 0; k < 3; k++) begin
      v = $random(seed);
      wr(adr[k], v | 32'h80);
      rdc(k);
    end
    effc;
    pstrb <= 4'he;
    wr(adr[0], 32'hff);
    pstrb <= 4'hf;
    clk_en <= 0;
    wr(adr[1], 32'h85);
    clk_en <= 1;
    rdc(0);
    rdc(1);
    for (k = 0; k < 3; k++) begin
      wr(adr[k], 0);
      rdc(k);
    end
    effc;
    wr(12'h004, 32'hff);
    chk({31'h0, e}, 1);
    apb(12'h004, 0, 0);
    chk(r, 0);
    test_done;
  end
endmodule
`default_nettype wire
